// ==== hdl/sbnm_ms_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbnm_ms_tick #(
  parameter int unsigned CYCLES = 32'd200000
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);

  logic [31:0] cnt;
  wire logic wrap = (cnt == CYCLES - 32'd1);

  // Free-running divider; the tick is one cycle wide once per period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 32'h00000000;
      tick <= 1'b0;
    end else begin
      cnt <= wrap ? 32'h00000000 : cnt + 32'd1;
      tick <= wrap;
    end
  end

endmodule : sbnm_ms_tick
`default_nettype wire

// ==== hdl/sbnm_pkg.sv ====
package sbnm_pkg;

  // Clock and millisecond base used by the receive sampling and the boot-up delay.
  localparam int CLK_PERIOD_NS = 5;
  localparam int RX_SAMPLE_PERIOD_MS = 1;
  localparam int unsigned MS_CYCLES_DFLT = RX_SAMPLE_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

  // Register byte offsets; the three transmit period words are consecutive.
  localparam logic [7:0] ADDR_STATION = 8'h00;
  localparam logic [7:0] ADDR_BOOT_DELAY = 8'h04;
  localparam logic [7:0] ADDR_CHAN_MODE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_TX_PERIOD0 = 8'h10;
  localparam logic [7:0] ADDR_TX_PERIOD2 = 8'h18;

  // Station number encoding, unsigned in eight bits.
  localparam logic [7:0] STATION_OFF = 8'hFF;
  localparam logic [7:0] STATION_MASTER = 8'h00;
  localparam logic [7:0] STATION_MAX = 8'h3F;

  // Boot-up delay and transmit period in milliseconds.
  localparam logic [15:0] BOOT_DELAY_MIN = 16'h0DAC;
  localparam logic [15:0] BOOT_DELAY_MAX = 16'hC350;
  localparam logic [15:0] BOOT_DELAY_RST = 16'h0DAC;
  localparam logic [15:0] TX_PERIOD_RST = 16'h0064;

  // Channel mode word layout and mode codes.
  localparam int MODE_TX_LSB = 0;
  localparam int MODE_RX_LSB = 6;
  localparam logic [11:0] CHAN_MODE_RST = 12'h000;
  localparam logic [1:0] PM_OFF = 2'h0;
  localparam logic [1:0] PM_TIME = 2'h1;
  localparam logic [1:0] PM_SYNC = 2'h2;

  // Status word bit positions.
  localparam int ST_MASTER = 3;
  localparam int ST_ACTIVE = 4;
  localparam int ST_PARAM = 5;
  localparam int ST_PDO = 6;

  // Frame identifiers and command codes.
  localparam logic [10:0] NMT_ID = 11'h000;
  localparam logic [10:0] SYNC_ID = 11'h080;
  localparam logic [10:0] BOOT_ID_BASE = 11'h700;
  localparam int TXPDO_BASE = 384;
  localparam int RXPDO_BASE = 512;
  localparam int PDO_ID_STEP = 256;
  localparam logic [7:0] CS_START = 8'h01;
  localparam logic [7:0] CS_STOP = 8'h02;
  localparam logic [7:0] CS_PREOP = 8'h80;
  localparam logic [7:0] CS_RST_NODE = 8'h81;
  localparam logic [7:0] CS_RST_COMM = 8'h82;
  localparam logic [7:0] BOOT_PAYLOAD = 8'h00;
  localparam logic [3:0] NMT_DLC = 4'h2;
  localparam logic [3:0] BOOT_DLC = 4'h1;
  localparam logic [3:0] PDO_DLC = 4'h2;

  // Transmit sources, lowest index wins arbitration.
  localparam logic [2:0] SRC_START = 3'h0;
  localparam logic [2:0] SRC_BOOT = 3'h1;
  localparam logic [2:0] SRC_PDO0 = 3'h2;

  typedef enum logic [2:0] {NS_OFF, NS_INIT, NS_PREOP, NS_OP, NS_STOP} sbnm_state_t;

endpackage : sbnm_pkg

// ==== hdl/sbnm_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbnm_top
  import sbnm_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DFLT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic rx_error,
  input wire logic [10:0] rx_id,
  input wire logic [3:0] rx_dlc,
  input wire logic [15:0] rx_data,
  output logic tx_valid,
  output logic [10:0] tx_id,
  output logic [3:0] tx_dlc,
  output logic [15:0] tx_data,
  input wire logic tx_done,
  input wire logic tx_fail,
  input wire logic [2:0][15:0] app_tx_data,
  output logic [2:0][15:0] app_rx_data,
  output logic [2:0] app_rx_strobe,
  input wire logic sdo_req_valid,
  input wire logic sdo_req_expedited,
  output logic sdo_req_accept,
  output logic [1:0] sdo_client,
  output logic [1:0] sdo_server,
  output logic param_enable,
  output logic pdo_enable
);

  sbnm_state_t state;
  sbnm_state_t next_state;
  logic [7:0] station;
  logic [15:0] boot_delay;
  logic [11:0] chan_mode;
  logic [15:0] tx_period [3];
  logic [15:0] tx_latch [3];
  logic [15:0] boot_cnt;
  logic [4:0] pend;
  logic [4:0] pdo_set;
  logic [2:0] tx_src;
  logic ms_tick;

  // Millisecond time base shared by sampling, periods and the boot-up delay.
  sbnm_ms_tick #(
    .CYCLES(MS_CYCLES)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(ms_tick)
  );

  // Bus decode: zero-wait slave, unmapped offsets answer with an error.
  wire logic apb_setup = psel & ~penable;
  wire logic apb_wr = psel & penable & pwrite;
  wire logic [7:0] reg_off = paddr[7:0];
  wire logic page_ok = (paddr[31:8] == 24'h000000) & (paddr[1:0] == 2'b00);
  wire logic sel_station = page_ok & (reg_off == ADDR_STATION);
  wire logic sel_boot = page_ok & (reg_off == ADDR_BOOT_DELAY);
  wire logic sel_mode = page_ok & (reg_off == ADDR_CHAN_MODE);
  wire logic sel_status = page_ok & (reg_off == ADDR_STATUS);
  wire logic sel_period = page_ok & (reg_off >= ADDR_TX_PERIOD0) & (reg_off <= ADDR_TX_PERIOD2);
  wire logic [1:0] period_idx = 2'(reg_off[7:2] - ADDR_TX_PERIOD0[7:2]);
  wire logic mapped = sel_station | sel_boot | sel_mode | sel_status | sel_period;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  wire logic station_legal = (pwdata[7:0] == STATION_OFF) | (pwdata[7:0] <= STATION_MAX);
  wire logic sta_wr = apb_wr & sel_station & station_legal;
  wire logic [15:0] boot_wdata = pwdata[15:0];
  wire logic [15:0] boot_clamped = (boot_wdata < BOOT_DELAY_MIN) ? BOOT_DELAY_MIN :
                                   (boot_wdata > BOOT_DELAY_MAX) ? BOOT_DELAY_MAX : boot_wdata;

  // Role derived from the station number.
  wire logic active = (station != STATION_OFF);
  wire logic is_master = (station == STATION_MASTER);
  wire logic [10:0] sid = {4'h0, station[6:0]};

  assign param_enable = (state == NS_PREOP) | (state == NS_OP);
  assign pdo_enable = (state == NS_OP);

  // Parameter channel roles; channel 0 becomes the client on the master.
  assign sdo_client = {1'b0, active & is_master};
  assign sdo_server = {active, active & ~is_master};

  // Segmented requests are refused; only expedited ones pass.
  assign sdo_req_accept = sdo_req_valid & sdo_req_expedited & param_enable;

  // Status word shows the node's own state and role.
  wire logic [31:0] status_word = {25'h0000000, pdo_enable, param_enable, active, is_master,
                                   3'(state)};
  wire logic [31:0] rd_mux = sel_station ? {24'h000000, station} :
                             sel_boot ? {16'h0000, boot_delay} :
                             sel_mode ? {20'h00000, chan_mode} :
                             sel_status ? status_word :
                             sel_period ? {16'h0000, tx_period[period_idx]} : 32'h00000000;

  // Read data is captured in the setup cycle so that it stands through the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (apb_setup) begin
      prdata <= rd_mux;
    end
  end

  // Configuration registers; a rejected station value leaves the old one in place.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      station <= STATION_OFF;
      boot_delay <= BOOT_DELAY_RST;
      chan_mode <= CHAN_MODE_RST;
    end else begin
      if (sta_wr) begin
        station <= pwdata[7:0];
      end
      if (apb_wr & sel_boot) begin
        boot_delay <= boot_clamped;
      end
      if (apb_wr & sel_mode) begin
        chan_mode <= pwdata[11:0];
      end
    end
  end

  // Only clean frames are seen at all; nothing is seen while off.
  wire logic frame_ok = rx_valid & ~rx_error & active;
  wire logic sync_seen = frame_ok & (rx_id == SYNC_ID);
  wire logic [7:0] nmt_cs = rx_data[7:0];
  wire logic [7:0] nmt_target = rx_data[15:8];
  // Broadcast or own station; identifier 0 with at least two bytes.
  wire logic nmt_ok = frame_ok & (rx_id == NMT_ID) & (rx_dlc >= NMT_DLC) & ~is_master &
                      ((nmt_target == 8'h00) | (nmt_target == station));
  wire logic tx_ok = tx_valid & tx_done & ~tx_fail;
  wire logic self_start = is_master & tx_ok & (tx_src == SRC_START);
  wire logic reinit = (next_state == NS_INIT) | (next_state == NS_OFF);

  // Node state machine; a legal station write restarts the node from scratch, or switches it off if the value is STATION_OFF.
  always_comb begin
    next_state = state;
    if (sta_wr) begin
      next_state = (pwdata[7:0] == STATION_OFF) ? NS_OFF : NS_INIT;
    end else begin
      unique case (state)
        NS_OFF: begin
          next_state = NS_OFF;
        end
        NS_INIT: begin
          next_state = NS_PREOP;
        end
        NS_PREOP, NS_OP, NS_STOP: begin
          // Command decode; unknown codes are ignored.
          if (nmt_ok & (nmt_cs == CS_START)) begin
            next_state = NS_OP;
          end else if (nmt_ok & (nmt_cs == CS_PREOP)) begin
            next_state = NS_PREOP;
          end else if (nmt_ok & (nmt_cs == CS_STOP)) begin
            next_state = NS_STOP;
          end else if (nmt_ok & ((nmt_cs == CS_RST_NODE) | (nmt_cs == CS_RST_COMM))) begin
            // Reset commands go back through initialization.
            next_state = NS_INIT;
          end else if (self_start) begin
            next_state = NS_OP;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= NS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Boot-up delay counting starts once initialization is over.
  wire logic master_run = is_master & ((state == NS_PREOP) | (state == NS_OP));
  wire logic boot_due = master_run & ms_tick & ((boot_cnt + 16'd1) >= boot_delay);

  // The counter wraps on every broadcast, giving the repeat interval.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_cnt <= 16'h0000;
    end else if (!master_run | boot_due) begin
      boot_cnt <= 16'h0000;
    end else if (ms_tick) begin
      boot_cnt <= boot_cnt + 16'd1;
    end
  end

  // A slave announces itself once per pass through initialization.
  wire logic boot_set = (state == NS_INIT) & ~is_master & ~sta_wr;

  // Pending sources; a new request in the cycle of its clear is kept.
  wire logic [4:0] pend_set = {pdo_set[4:2], boot_set, boot_due};
  wire logic [4:0] pend_clr = tx_ok ? (5'h01 << tx_src) : 5'h00;
  wire logic [4:0] pend_flush = reinit ? 5'h1F : (next_state != NS_OP) ? 5'h1C : 5'h00;
  wire logic [4:0] next_pend = ((pend & ~pend_clr) | pend_set) & ~pend_flush;

  // Lowest pending index is chosen; management frames outrank process data.
  wire logic [2:0] pick = pend[0] ? 3'h0 : pend[1] ? 3'h1 : pend[2] ? 3'h2 :
                          pend[3] ? 3'h3 : 3'h4;
  wire logic [1:0] pdo_pick = 2'(pick - SRC_PDO0);
  wire logic [10:0] pdo_cob = 11'(TXPDO_BASE + PDO_ID_STEP * int'(pdo_pick)) + sid;

  // Start is built only as broadcast; target byte stays zero.
  wire logic [10:0] load_id = (pick == SRC_START) ? NMT_ID :
                              (pick == SRC_BOOT) ? BOOT_ID_BASE + sid : pdo_cob;
  wire logic [3:0] load_dlc = (pick == SRC_START) ? NMT_DLC :
                              (pick == SRC_BOOT) ? BOOT_DLC : PDO_DLC;
  wire logic [15:0] load_data = (pick == SRC_START) ? {8'h00, CS_START} :
                                (pick == SRC_BOOT) ? {8'h00, BOOT_PAYLOAD} : tx_latch[pdo_pick];
  wire logic load = ~tx_valid & (pend != 5'h00) & ~reinit;

  // A failed send keeps the frame offered until it goes through or the node reinitializes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 5'h00;
      tx_valid <= 1'b0;
      tx_src <= SRC_START;
      tx_id <= NMT_ID;
      tx_dlc <= 4'h0;
      tx_data <= 16'h0000;
    end else begin
      pend <= next_pend;
      if (reinit | tx_ok) begin
        tx_valid <= 1'b0;
      end else if (load) begin
        tx_valid <= 1'b1;
        tx_src <= pick;
        tx_id <= load_id;
        tx_dlc <= load_dlc;
        tx_data <= load_data;
      end
    end
  end

  assign pdo_set[1:0] = 2'b00;

  // One slice per channel pair, each with its own mode fields.
  for (genvar ch = 0; ch < 3; ch++) begin : g_ch
    wire logic [1:0] tx_mode = chan_mode[MODE_TX_LSB + 2 * ch +: 2];
    wire logic [1:0] rx_mode = chan_mode[MODE_RX_LSB + 2 * ch +: 2];
    wire logic [10:0] rx_cob = 11'(RXPDO_BASE + PDO_ID_STEP * ch) + sid;
    logic [15:0] per_cnt;
    logic [15:0] rx_buf;
    // Code 3 falls through as disabled.
    wire logic tx_time = pdo_enable & (tx_mode == PM_TIME);
    wire logic tx_sync = pdo_enable & (tx_mode == PM_SYNC);
    // Cyclic send at the configured period; a zero period acts as one ms.
    wire logic per_due = tx_time & ms_tick & ((per_cnt + 16'd1) >= tx_period[ch]);
    wire logic rx_hit = frame_ok & pdo_enable & (rx_mode != PM_OFF) & (rx_mode != 2'h3) &
                        (rx_id == rx_cob) & (rx_dlc >= PDO_DLC);
    // Forward at SYNC in sync mode, or on the sampling tick in time mode.
    wire logic rx_fwd = pdo_enable & ~reinit & (((rx_mode == PM_TIME) & ms_tick) |
                                      ((rx_mode == PM_SYNC) & sync_seen));
    assign pdo_set[ch + 2] = per_due | (tx_sync & sync_seen);

    // Period, latch and receive holding registers for this pair.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tx_period[ch] <= TX_PERIOD_RST;
        per_cnt <= 16'h0000;
        tx_latch[ch] <= 16'h0000;
        rx_buf <= 16'h0000;
        app_rx_data[ch] <= 16'h0000;
        app_rx_strobe[ch] <= 1'b0;
      end else begin
        if (apb_wr & sel_period & (period_idx == 2'(ch))) begin
          tx_period[ch] <= pwdata[15:0];
        end
        per_cnt <= (!tx_time | per_due) ? 16'h0000 : per_cnt + {15'h0000, ms_tick};
        // Application values are captured at the triggering moment.
        if (pdo_set[ch + 2]) begin
          tx_latch[ch] <= app_tx_data[ch];
        end
        if (rx_hit) begin
          rx_buf <= rx_data;
        end
        if (rx_fwd) begin
          app_rx_data[ch] <= rx_buf;
        end
        app_rx_strobe[ch] <= rx_fwd;
      end
    end

    a_sync_rx_fwd: assert property (@(posedge pclk) disable iff (!presetn)
      app_rx_strobe[ch] && rx_mode == PM_SYNC && $stable(rx_mode) |-> $past(sync_seen))
      else $error("receive data forwarded without SYNC");
    a_sync_tx_latch: assert property (@(posedge pclk) disable iff (!presetn)
      tx_sync && sync_seen |=> tx_latch[ch] == $past(app_tx_data[ch]))
      else $error("transmit value not latched at SYNC");
    a_time_rx_tick: assert property (@(posedge pclk) disable iff (!presetn)
      app_rx_strobe[ch] && rx_mode == PM_TIME && $stable(rx_mode) |-> $past(ms_tick))
      else $error("time mode forward off the sampling tick");
  end

  a_station_range: assert property (@(posedge pclk) disable iff (!presetn)
    station == STATION_OFF || station <= STATION_MAX)
    else $error("station number out of range");
  a_off_silent: assert property (@(posedge pclk) disable iff (!presetn)
    state == NS_OFF |-> !tx_valid && !param_enable && app_rx_strobe == 3'b000)
    else $error("deactivated node is active");
  a_error_discard: assert property (@(posedge pclk) disable iff (!presetn)
    rx_valid && rx_error && !sta_wr && !self_start && state != NS_INIT |=> $stable(state))
    else $error("faulty frame changed state");
  a_start_op: assert property (@(posedge pclk) disable iff (!presetn)
    nmt_ok && nmt_cs == CS_START && !sta_wr && state != NS_INIT |=> state == NS_OP)
    else $error("start command not obeyed");
  a_stop_gate: assert property (@(posedge pclk) disable iff (!presetn)
    state == NS_STOP |-> !param_enable && !pdo_enable && !sdo_req_accept)
    else $error("stopped node not gated");
  a_start_bcast: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid && tx_id == NMT_ID |-> tx_data == {8'h00, CS_START} && is_master)
    else $error("start not sent as broadcast");
  a_init_preop: assert property (@(posedge pclk) disable iff (!presetn)
    state == NS_INIT && !sta_wr |=> state == NS_PREOP)
    else $error("initialization did not end in pre-operational");
  a_reset_cmd: assert property (@(posedge pclk) disable iff (!presetn)
    nmt_ok && (nmt_cs == CS_RST_NODE || nmt_cs == CS_RST_COMM) && !sta_wr &&
    state != NS_INIT |=> state == NS_INIT ##1 state == NS_PREOP)
    else $error("reset command did not reinitialize");
  a_boot_frame: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid && tx_src == SRC_BOOT |-> tx_id == BOOT_ID_BASE + sid && tx_dlc == BOOT_DLC &&
    tx_data[7:0] == BOOT_PAYLOAD)
    else $error("boot-up frame malformed");
  a_boot_delay: assert property (@(posedge pclk) disable iff (!presetn)
    boot_due |-> boot_cnt + 16'd1 >= boot_delay && boot_delay >= BOOT_DELAY_MIN)
    else $error("start sent before boot-up delay");

endmodule : sbnm_top
`default_nettype wire

// ==== testbench/sbnm_can_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Frame controller on the far side: it acknowledges each offered frame after a delay.
module sbnm_can_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_valid,
  input wire logic fail_req,
  input wire logic [3:0] slow,
  output logic tx_done,
  output logic tx_fail
);
  logic [3:0] cnt;
  // bus retry
  // A refused attempt leaves the frame offered, so the same frame is tried again.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      tx_done <= 1'b0;
      tx_fail <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      tx_fail <= 1'b0;
      if (tx_valid && !tx_done) begin
        cnt <= cnt + 4'h1;
        if (cnt >= slow) begin
          cnt <= 4'h0;
          tx_done <= 1'b1;
          tx_fail <= fail_req;
        end
      end else begin
        cnt <= 4'h0;
      end
    end
  end
endmodule : sbnm_can_model
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sbnm_pkg::*;
  localparam int MSC = 10;
  localparam int DLY = 3500 * MSC;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q, seed = 32'h5;
  logic pready, pslverr, rx_valid = 1'b0, rx_error = 1'b0, err;
  logic [10:0] rx_id = 11'h0, tx_id;
  logic [3:0] rx_dlc = 4'h2, tx_dlc, slow = 4'h2;
  logic [15:0] rx_data = 16'h0, tx_data;
  logic tx_valid, tx_done, tx_fail, fail_req = 1'b0;
  logic [2:0][15:0] app_tx_data = '0, app_rx_data;
  logic [2:0] app_rx_strobe;
  logic sdo_req_valid = 1'b0, sdo_req_expedited = 1'b0, sdo_req_accept;
  logic [1:0] sdo_client, sdo_server;
  logic param_enable, pdo_enable;
  int failures = 0, n_tests = 0, t;
  // Command, target, error flag and resulting state for each management frame.
  logic [23:0] tbl [11] = '{24'h010602, 24'h010512, 24'h010503, 24'h020004, 24'h800502,
    24'h010003, 24'h810502, 24'h010503, 24'h820002, 24'h010003, 24'h030003};
  sbnm_top #(.MS_CYCLES(MSC)) uut (.*);
  sbnm_can_model can (.*);
  // Free-running clock.
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Expected status bits followed by the two enable outputs.
  function automatic logic [8:0] exp_st(input logic [2:0] s, input logic m);
    logic p;
    p = (s == 3'h2) || (s == 3'h3);
    return {s == 3'h3, p, s != 3'h0, m, s, p, s == 3'h3};
  endfunction : exp_st
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Idle receive lines show the inverse of the last frame, never a stale copy.
  task automatic rx(input logic [10:0] id, input logic [15:0] d, input logic e);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_error <= e;
    rx_id <= id;
    rx_data <= d;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_error <= 1'b0;
    rx_id <= ~id;
    rx_data <= ~d;
  endtask : rx
  task automatic wait_tx(input logic [30:0] f, input int lim);
    for (t = 0; t < lim; t++) begin
      @(posedge pclk);
      if (tx_valid === 1'b1 && tx_done === 1'b1 && tx_fail === 1'b0
          && tx_id === f[26:16]) break;
    end
    chk("tx_timeout", t < lim, 1'b1);
    chk("tx_frame", {1'b0, tx_dlc, tx_id, tx_data}, {1'b0, f});
  endtask : wait_tx
  task automatic st(input logic [2:0] s, input logic m);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", {q[6:0], param_enable, pdo_enable}, exp_st(s, m));
  endtask : st
  task automatic sdo(input logic p, input logic [3:0] cs);
    q = rnd();
    @(posedge pclk);
    sdo_req_valid <= 1'b1;
    sdo_req_expedited <= q[0];
    @(negedge pclk);
    chk("sdo", {sdo_req_accept, sdo_client, sdo_server}, {p & q[0], cs});
  endtask : sdo
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // Cuts a hang short; the master test alone needs about two boot-up delays.
  initial begin
    repeat (2 * DLY + 20000) @(posedge pclk);
    failures++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_STATION, 32'h0);
    chk("station", q[7:0], STATION_OFF);
    apb(1'b1, ADDR_STATION, 32'h40);
    apb(1'b0, ADDR_STATION, 32'h0);
    chk("station_range", q[7:0], STATION_OFF);
    st(3'h0, 1'b0);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", err, 1'b1);
    $display("test reset done");
    fail_req <= 1'b1;
    apb(1'b1, ADDR_STATION, 32'h5);
    for (int i = 0; i < 50 && tx_done !== 1'b1; i++) @(posedge pclk);
    fail_req <= 1'b0;
    chk("first_try", tx_fail, 1'b1);
    wait_tx({BOOT_DLC, BOOT_ID_BASE + 11'h5, 16'h0}, 60);
    st(3'h2, 1'b0);
    $display("test boot done");
    foreach (tbl[i]) begin
      rx(NMT_ID, {tbl[i][15:8], tbl[i][23:16]}, tbl[i][4]);
      if (tbl[i][23:16] > 8'h80) wait_tx({BOOT_DLC, BOOT_ID_BASE + 11'h5, 16'h0}, 60);
      st(tbl[i][2:0], 1'b0);
      sdo(!tbl[i][2], 4'b0011);
    end
    $display("test management done");
    q = rnd();
    app_tx_data[0] <= q[15:0];
    app_tx_data[1] <= q[31:16];
    app_tx_data[2] <= ~q[15:0];
    apb(1'b1, ADDR_TX_PERIOD0, 32'h2);
    apb(1'b1, ADDR_CHAN_MODE, 32'h189);
    wait_tx({PDO_DLC, 11'h185, app_tx_data[0]}, 200);
    q = rnd();
    slow <= q[3:0] | 4'h8;
    rx(11'h205, q[15:0], 1'b0);
    rx(SYNC_ID, 16'h0, 1'b0);
    for (int i = 0; i < 5 && app_rx_strobe[0] !== 1'b1; i++) @(negedge pclk);
    chk("rx_sync", {app_rx_strobe[0], app_rx_data[0]}, {1'b1, q[15:0]});
    wait_tx({PDO_DLC, 11'h285, app_tx_data[1]}, 200);
    rx(11'h305, ~q[15:0], 1'b0);
    repeat (2) @(negedge pclk);
    for (int i = 0; i < 2 * MSC && app_rx_strobe[1] !== 1'b1; i++) @(negedge pclk);
    chk("rx_time", {app_rx_strobe[1], app_rx_data[1]}, {1'b1, ~q[15:0]});
    rx_dlc <= 4'h1;
    rx(NMT_ID, 16'h0002, 1'b0);
    rx_dlc <= 4'h2;
    st(3'h3, 1'b0);
    rx(NMT_ID, 16'h0502, 1'b0);
    st(3'h4, 1'b0);
    apb(1'b1, ADDR_STATION, 32'hFF);
    rx(NMT_ID, 16'h0001, 1'b0);
    st(3'h0, 1'b0);
    $display("test process data done");
    apb(1'b1, ADDR_BOOT_DELAY, 32'd1000);
    apb(1'b0, ADDR_BOOT_DELAY, 32'h0);
    chk("boot_delay", q[15:0], BOOT_DELAY_MIN);
    slow <= 4'h1;
    apb(1'b1, ADDR_STATION, 32'h0);
    sdo(1'b1, 4'b0110);
    wait_tx({NMT_DLC, NMT_ID, 16'h0001}, DLY + 500);
    chk("first_start", t >= DLY - 3 * MSC && t <= DLY + MSC, 1'b1);
    wait_tx({NMT_DLC, NMT_ID, 16'h0001}, DLY + 500);
    chk("repeat_start", t >= DLY - 3 * MSC && t <= DLY + MSC, 1'b1);
    st(3'h3, 1'b1);
    $display("test master done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
